// >>> test/hcpi_host_model.sv
// Host side model: builds command reports, sends them, collects replies.
module hcpi_host_model (
	input wire logic clk_sys,
	output logic rx_valid,
	output logic [7:0] rx_data,
	output logic rx_sop,
	output logic rx_eop,
	input wire logic rx_ready,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_last,
	output logic tx_ready
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] pkt[$];
	logic [7:0] rep[$];
	logic got_last = 1'b0;
	logic slow = 1'b0;
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h5A;
		rx_sop = 1'b0;
		rx_eop = 1'b0;
		tx_ready = 1'b1;
	end
	// A slow sink drops ready every other cycle so the reply must wait.
	always @(posedge clk_sys) begin
		tx_ready <= slow ? ~tx_ready : 1'b1;
		if (tx_valid && tx_ready) begin
			rep.push_back(tx_data);
			if (tx_last) begin
				got_last <= 1'b1;
			end
		end
	end
	task build(input logic [7:0] f, input logic [7:0] s,
		input logic [7:0] o1, input logic [7:0] o2,
		input logic [63:0] pay, input int np);
		pkt.delete();
		pkt.push_back(8'h00);
		pkt.push_back(f);
		pkt.push_back(s);
		pkt.push_back(8'(np + 2));
		pkt.push_back(8'h00);
		pkt.push_back(o1);
		pkt.push_back(o2);
		for (int i = 0; i < np; i++) begin
			pkt.push_back(pay[8*i +: 8]);
		end
	endtask : build
	// Reports go out as built; only the error scenario exceeds 64 bytes.
	task send;
		for (int i = 0; i < pkt.size(); i++) begin
			rx_valid <= 1'b1;
			rx_data <= pkt[i];
			rx_sop <= (i == 0);
			rx_eop <= (i == pkt.size() - 1);
			do @(posedge clk_sys); while (rx_ready !== 1'b1);
		end
		rx_valid <= 1'b0;
		rx_sop <= 1'b0;
		rx_eop <= 1'b0;
		rx_data <= ~pkt[pkt.size() - 1];
	endtask : send
endmodule : hcpi_host_model

// >>> test/testbench.sv
// Self-checking bench for the command packet interpreter.
module testbench import hcpi_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys, rstn, psel, penable, pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic pready, pslverr, e, rx_valid, rx_sop, rx_eop, rx_ready;
	logic [7:0] rx_data, tx_data;
	logic tx_valid, tx_last, tx_ready, hibernate, irq;
	int n_fail = 0;
	int tests_run = 0;
	int cycles = 0;
	hcpi_top hcpi_top_inst (.clk_sys, .rstn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .rx_valid, .rx_data,
		.rx_sop, .rx_eop, .rx_ready, .tx_valid, .tx_data, .tx_last,
		.tx_ready, .hibernate, .irq);
	hcpi_host_model hcpi_host_model_inst (.clk_sys, .rx_valid, .rx_data,
		.rx_sop, .rx_eop, .rx_ready, .tx_valid, .tx_data, .tx_last,
		.tx_ready);
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	task print_verdict;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : print_verdict
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_fail++;
			print_verdict();
		end
	end
	task check(input string nm, input logic [31:0] x, input logic [31:0] g);
		tests_run++;
		if (g !== x) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, x, g);
		end
	endtask : check
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask : apb
	task go;
		int k;
		hcpi_host_model_inst.rep.delete();
		hcpi_host_model_inst.got_last = 1'b0;
		hcpi_host_model_inst.send();
		k = 0;
		while (hcpi_host_model_inst.got_last !== 1'b1 && k < 100) begin
			@(posedge clk_sys);
			k++;
		end
	endtask : go
	task cmd(input logic [7:0] f, input logic [7:0] s, input logic [7:0] o1,
		input logic [7:0] o2, input logic [63:0] pay, input int np);
		hcpi_host_model_inst.build(f, s, o1, o2, pay, np);
		go();
	endtask : cmd
	task reply(input string nm, input logic [7:0] st, input logic [7:0] s,
		input int dl, input logic [63:0] d);
		check({nm, " last"}, 32'h1, 32'(hcpi_host_model_inst.got_last));
		check({nm, " size"}, 32'(4 + dl),
			32'(hcpi_host_model_inst.rep.size()));
		if (hcpi_host_model_inst.rep.size() == 4 + dl) begin
			check(nm, {8'(0), 8'(dl), s, st},
				{hcpi_host_model_inst.rep[3], hcpi_host_model_inst.rep[2],
				hcpi_host_model_inst.rep[1], hcpi_host_model_inst.rep[0]});
			for (int i = 0; i < dl; i++) begin
				check(nm, 32'(d[8*i +: 8]), 32'(hcpi_host_model_inst.rep[4+i]));
			end
		end
	endtask : reply
	task t_regs;
		apb(1'b0, A_CTRL, 32'h0);
		check("ctrl reset", 32'h0000_0001, r);
		apb(1'b0, A_STAT, 32'h0);
		check("status reset", 32'h0000_0000, r);
		apb(1'b0, A_MASK, 32'h0);
		check("mask reset", 32'h0000_0000, r);
		apb(1'b0, 8'h30, 32'h0);
		check("unmapped", 32'h0000_0001, {31'h0, e});
	endtask : t_regs
	task t_reads;
		logic [7:0] o1[6] = '{OP1_ENV, OP1_ENV, OP1_ENV, OP1_ENV,
			OP1_STORE, OP1_STORE};
		logic [7:0] o2[6] = '{OP2_AMB_TEMP, OP2_HUMID, OP2_BATT,
			OP2_CTRL_TEMP, OP2_FILES, OP2_PHOTO};
		for (int i = 0; i < 6; i++) begin
			apb(1'b1, A_DATA0 + 8'(4 * i), 32'hA1B2_C3D0 + 32'(i));
			hcpi_host_model_inst.slow = i[0];
			cmd(8'hC0, 8'h10 + 8'(i), o1[i], o2[i], 64'h0, 0);
			reply("read", 8'hC0, 8'h10 + 8'(i), 4,
				64'(32'hA1B2_C3D0 + 32'(i)));
		end
		hcpi_host_model_inst.slow = 1'b0;
	endtask : t_reads
	task t_time;
		apb(1'b0, A_STAT, 32'h0);
		cmd(8'h40, 8'h00, OP1_ENV, OP2_TIME_SET,
			64'h8877_6655_4433_2211, 8);
		reply("time set", 8'h40, 8'h00, 0, 64'h0);
		apb(1'b0, A_STAT, 32'h0);
		check("time event", 32'(1 << EV_TIME), r & 32'(1 << EV_TIME));
		apb(1'b0, 8'h28, 32'h0);
		check("time low", 32'h4433_2211, r);
		apb(1'b0, 8'h2C, 32'h0);
		check("time high", 32'h8877_6655, r);
		cmd(8'hC0, 8'h03, OP1_ENV, OP2_TIME_GET, 64'h0, 0);
		reply("time get", 8'hC0, 8'h03, 8, 64'h8877_6655_4433_2211);
	endtask : t_time
	task t_quiet;
		cmd(8'h00, 8'h09, OP1_ENV, OP2_HIBERNATE, 64'h0, 0);
		check("silent", 32'h0, 32'(hcpi_host_model_inst.rep.size()));
		check("hibernate", 32'h1, {31'h0, hibernate});
		apb(1'b0, A_INFO, 32'h0);
		check("info", 32'h0003_0D01, r);
		apb(1'b1, A_CTRL, 32'h0000_0003);
		check("wake", 32'h0, {31'h0, hibernate});
	endtask : t_quiet
	task t_nack;
		cmd(8'hC0, 8'h07, 8'h05, 8'h55, 64'h0, 0);
		reply("unknown", 8'hE0, 8'h07, 0, 64'h0);
		cmd(8'hC0, 8'h08, OP1_ENV, OP2_HIBERNATE, 64'h0, 0);
		reply("read flag on write", 8'hE0, 8'h08, 0, 64'h0);
		apb(1'b1, A_CTRL, 32'h0000_0003);
		apb(1'b0, A_STAT, 32'h0);
		hcpi_host_model_inst.build(8'h00, 8'h00, OP1_ENV, OP2_HUMID, 64'h0, 0);
		hcpi_host_model_inst.pkt[0] = 8'h01;
		go();
		apb(1'b0, A_STAT, 32'h0);
		check("bad id", 32'h1, 32'(r[EV_ERR]));
		// A length of 60 makes the report 65 bytes, one over the limit.
		hcpi_host_model_inst.build(8'hC0, 8'h0A, OP1_ENV, OP2_HUMID, 64'h0, 0);
		hcpi_host_model_inst.pkt[3] = 8'h3C;
		repeat (58) hcpi_host_model_inst.pkt.push_back(8'h00);
		go();
		reply("oversize", 8'hE0, 8'h0A, 0, 64'h0);
		apb(1'b0, A_STAT, 32'h0);
		check("oversize", 32'h1, 32'(r[EV_ERR]));
	endtask : t_nack
	// Split command: opcode byte 2 comes in a continuation report.
	task t_multi;
		logic [7:0] nxt[2] = '{8'h02, 8'h05};
		for (int i = 0; i < 2; i++) begin
			hcpi_host_model_inst.build(8'hC0, 8'h01, OP1_ENV, OP2_AMB_TEMP,
				64'h0, 0);
			void'(hcpi_host_model_inst.pkt.pop_back());
			hcpi_host_model_inst.send();
			@(posedge clk_sys);
			hcpi_host_model_inst.pkt = '{8'h00, 8'h00, nxt[i], OP2_AMB_TEMP};
			go();
			if (i == 0) begin
				reply("split", 8'hC0, 8'h01, 4, 64'hA1B2_C3D0);
			end else begin
				reply("bad order", 8'hE0, 8'h01, 0, 64'h0);
			end
		end
	endtask : t_multi
	task t_irq;
		apb(1'b1, A_MASK, 32'(1 << EV_DONE));
		apb(1'b0, A_STAT, 32'h0);
		repeat (2) @(posedge clk_sys);
		check("irq idle", 32'h0, {31'h0, irq});
		cmd(8'hC0, 8'h00, OP1_ENV, OP2_HUMID, 64'h0, 0);
		repeat (2) @(posedge clk_sys);
		check("irq raised", 32'h1, {31'h0, irq});
		apb(1'b0, A_STAT, 32'h0);
		check("done event", 32'h1, 32'(r[EV_DONE]));
		repeat (2) @(posedge clk_sys);
		check("irq cleared", 32'h0, {31'h0, irq});
		apb(1'b1, A_MASK, 32'h0);
		cmd(8'hC0, 8'h00, OP1_ENV, OP2_HUMID, 64'h0, 0);
		repeat (2) @(posedge clk_sys);
		check("irq masked", 32'h0, {31'h0, irq});
	endtask : t_irq
	initial begin
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (6) @(posedge clk_sys);
		rstn <= 1'b1;
		@(posedge clk_sys);
		t_regs();
		t_reads();
		t_time();
		t_quiet();
		t_nack();
		t_multi();
		t_irq();
		print_verdict();
	end
endmodule : testbench

// >>> verilog/hcpi_pkg.sv
// Constants and types shared by the HID command packet interpreter files.
// Operation
// [RULE1] A packet opens with a report identifier byte of zero.
// [RULE2] Flags bit 6 asks for a reply, and the device replies only then.
// [RULE3] Flags bit 7 marks a read, which the device answers with data.
// [RULE4] Long commands span reports and are joined in sequence order.
// [RULE5] The sequence byte of a one-packet command carries no meaning.
// [RULE6] The two-byte length counts only the opcode and payload bytes.
// [RULE7] Two opcode bytes follow the length and select the command.
// [RULE8] Multi-byte values travel least significant byte first.
// [RULE9] No report on the link is longer than 64 bytes.
// [RULE10] A finished read returns the sequence byte, length and data.
// [RULE11] A requested reply flags unknown or failed commands as refused.
// [RULE12] A finished write is answered only when flags bit 6 was set.
// [RULE13] Group 0x03 reads temperatures, humidity and battery voltage.
// [RULE14] Group 0x03 also sets and reads the time and starts hibernation.
// [RULE15] Group 0x04 reads the scan file count and the photodetector.
// [RULE16] A write packet is expected with flags bit 7 clear.
package hcpi_pkg;
	localparam logic [6:0] PKT_MAX = 7'h40;
	localparam logic [7:0] RID_VALUE = 8'h00;
	localparam int FLG_REPLY = 6;
	localparam int FLG_READ = 7;
	localparam int ST_NACK = 5;
	localparam logic [15:0] OPC_BYTES = 16'h0002;
	localparam logic [15:0] TIME_PLEN = 16'h0008;
	localparam logic [3:0] PAY_KEEP = 4'h8;
	localparam logic [7:0] OP1_ENV = 8'h03;
	localparam logic [7:0] OP1_STORE = 8'h04;
	localparam logic [7:0] OP2_AMB_TEMP = 8'h00;
	localparam logic [7:0] OP2_HUMID = 8'h02;
	localparam logic [7:0] OP2_TIME_SET = 8'h09;
	localparam logic [7:0] OP2_BATT = 8'h0A;
	localparam logic [7:0] OP2_CTRL_TEMP = 8'h0B;
	localparam logic [7:0] OP2_TIME_GET = 8'h0C;
	localparam logic [7:0] OP2_HIBERNATE = 8'h0D;
	localparam logic [7:0] OP2_FILES = 8'h00;
	localparam logic [7:0] OP2_PHOTO = 8'h02;
	localparam logic [2:0] IX_AMB = 3'h0;
	localparam logic [2:0] IX_HUM = 3'h1;
	localparam logic [2:0] IX_BATT = 3'h2;
	localparam logic [2:0] IX_CTEMP = 3'h3;
	localparam logic [2:0] IX_FILES = 3'h4;
	localparam logic [2:0] IX_PHOTO = 3'h5;
	localparam logic [2:0] IX_TIME_LO = 3'h6;
	localparam logic [2:0] IX_TIME_HI = 3'h7;
	localparam logic [3:0] DLEN_WORD = 4'h4;
	localparam logic [3:0] DLEN_TIME = 4'h8;
	localparam logic [3:0] HDR_BYTES = 4'h4;
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_STAT = 8'h04;
	localparam logic [7:0] A_MASK = 8'h08;
	localparam logic [7:0] A_INFO = 8'h0C;
	localparam logic [7:0] A_DATA0 = 8'h10;
	localparam logic [7:0] A_LAST = 8'h2C;
	localparam int CTRL_EN = 0;
	localparam int CTRL_HIB_CLR = 1;
	localparam logic CTRL_EN_RESET = 1'b1;
	localparam int EV_DONE = 0;
	localparam int EV_NACK = 1;
	localparam int EV_TIME = 2;
	localparam int EV_HIB = 3;
	localparam int EV_ERR = 4;
	localparam int EV_W = 5;
	localparam logic [EV_W-1:0] MASK_RESET = 5'h00;
	typedef enum logic [9:0] {
		S_RID = 10'h001,
		S_FLG = 10'h002,
		S_SEQ = 10'h004,
		S_LEN0 = 10'h008,
		S_LEN1 = 10'h010,
		S_OP1 = 10'h020,
		S_OP2 = 10'h040,
		S_PAY = 10'h080,
		S_EXEC = 10'h100,
		S_SEND = 10'h200
	} hcpi_state_type;
endpackage : hcpi_pkg

// >>> verilog/hcpi_top.sv
// Command packet interpreter behind the HID report channel, APB registers.
module hcpi_top
	import hcpi_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic rx_sop,
	input wire logic rx_eop,
	output logic rx_ready,
	output logic tx_valid,
	output logic [7:0] tx_data,
	output logic tx_last,
	input wire logic tx_ready,
	output logic hibernate,
	output logic irq
);
	hcpi_state_type st_q;
	hcpi_state_type res_q;
	logic [7:0] flags_q;
	logic [7:0] seq_q;
	logic [7:0] seq_exp_q;
	logic [7:0] op1_q;
	logic [7:0] op2_q;
	logic [7:0] len_lo_q;
	logic [15:0] rem_q;
	logic [15:0] plen_q;
	logic [6:0] pcnt_q;
	logic [3:0] pidx_q;
	logic [63:0] pay_q;
	logic cont_q;
	logic err_q;
	logic rx_ready_q;
	logic [31:0] data_q [0:7];
	logic en_q;
	logic hib_q;
	logic [EV_W-1:0] stat_q;
	logic [EV_W-1:0] stat_d;
	logic [EV_W-1:0] mask_q;
	logic irq_q;
	logic pready_q;
	logic pslverr_q;
	logic [31:0] prdata_q;
	logic start_q;
	logic [7:0] rep_st_q;
	logic [3:0] rep_len_q;
	logic [63:0] rep_data_q;
	logic tx_done;
	logic acc;
	logic first;
	logic last;
	logic lenbad;
	logic early;
	logic go_exec;
	logic more;
	logic err_new;
	logic [5:0] info;
	logic known;
	logic rd;
	logic tm;
	logic badp;
	logic nack;
	logic exec;
	logic apb_acc;
	logic apb_hit;
	logic [EV_W-1:0] ev;

	// Returns {known, read, time, data index} for an opcode pair.
	function automatic logic [5:0] cmd_info(input logic [7:0] a,
		input logic [7:0] b);
		cmd_info = 6'h00;
		if (a == OP1_ENV) begin
			case (b)
			OP2_AMB_TEMP: cmd_info = {3'b110, IX_AMB}; // RULE13
			OP2_HUMID: cmd_info = {3'b110, IX_HUM}; // RULE13
			OP2_BATT: cmd_info = {3'b110, IX_BATT}; // RULE13
			OP2_CTRL_TEMP: cmd_info = {3'b110, IX_CTEMP}; // RULE13
			OP2_TIME_SET: cmd_info = {3'b101, IX_TIME_LO}; // RULE14
			OP2_TIME_GET: cmd_info = {3'b111, IX_TIME_LO}; // RULE14
			OP2_HIBERNATE: cmd_info = {3'b100, 3'h0}; // RULE14
			default: cmd_info = 6'h00;
			endcase
		end else if (a == OP1_STORE) begin
			case (b)
			OP2_FILES: cmd_info = {3'b110, IX_FILES}; // RULE15
			OP2_PHOTO: cmd_info = {3'b110, IX_PHOTO}; // RULE15
			default: cmd_info = 6'h00;
			endcase
		end
	endfunction : cmd_info

	assign acc = rx_valid & rx_ready_q;
	assign first = acc & (st_q == S_RID) & rx_sop & ~cont_q;
	assign last = acc & (st_q == S_OP2 || st_q == S_PAY) &
		(rem_q == 16'h0001);
	assign lenbad = acc & (st_q == S_LEN1) & ({rx_data, len_lo_q} < OPC_BYTES);
	assign early = acc & rx_eop &
		(st_q == S_FLG || st_q == S_SEQ || st_q == S_LEN0 ||
		st_q == S_LEN1 || (st_q == S_RID && rx_sop));
	assign go_exec = last | lenbad | early;
	// A report that ends inside the opcode or payload with bytes still owed continues in the next one.
	assign more = acc & rx_eop & ~last &
		(st_q == S_OP1 || st_q == S_OP2 || st_q == S_PAY); // RULE4
	assign err_new = lenbad | early |
		(acc & (st_q == S_RID) & rx_sop & (rx_data != RID_VALUE)) | // RULE1
		(acc & ~rx_sop & (pcnt_q >= PKT_MAX)) | // RULE9
		(acc & (st_q == S_SEQ) & cont_q & (rx_data != seq_exp_q)); // RULE4

	// Parser state.
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			st_q <= S_RID;
		end else if (go_exec) begin
			st_q <= S_EXEC;
		end else begin
			case (st_q)
			S_RID: if (acc && rx_sop) st_q <= S_FLG;
			S_FLG: if (acc) st_q <= S_SEQ;
			S_SEQ: if (acc) st_q <= cont_q ? res_q : S_LEN0;
			S_LEN0: if (acc) st_q <= S_LEN1;
			S_LEN1: if (acc) st_q <= S_OP1; // RULE6
			S_OP1: if (acc) st_q <= more ? S_RID : S_OP2; // RULE7
			S_OP2: if (acc) st_q <= more ? S_RID : S_PAY;
			S_PAY: if (more) st_q <= S_RID;
			S_EXEC: st_q <= flags_q[FLG_REPLY] ? S_SEND : S_RID; // RULE2
			S_SEND: if (tx_done) st_q <= S_RID;
			default: st_q <= S_RID;
			endcase
		end
	end

	// Receive readiness is dropped while a command executes or replies.
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			rx_ready_q <= 1'b0;
		end else begin
			rx_ready_q <= en_q & ((st_q != S_EXEC && st_q != S_SEND &&
				!go_exec) || (st_q == S_SEND && tx_done) ||
				(st_q == S_EXEC && !flags_q[FLG_REPLY]));
		end
	end

	// Header and payload capture.
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			flags_q <= 8'h00;
			seq_q <= 8'h00;
			seq_exp_q <= 8'h00;
			op1_q <= 8'h00;
			op2_q <= 8'h00;
			len_lo_q <= 8'h00;
			rem_q <= 16'h0000;
			plen_q <= 16'h0000;
			pcnt_q <= 7'h00;
			pidx_q <= 4'h0;
			pay_q <= '0;
			cont_q <= 1'b0;
			res_q <= S_PAY;
			err_q <= 1'b0;
		end else begin
			if (first) begin
				err_q <= err_new;
			end else begin
				err_q <= err_q | err_new;
			end
			if (acc) begin
				pcnt_q <= rx_sop ? 7'h01 : pcnt_q + 7'h01;
			end
			if (more) begin
				cont_q <= 1'b1;
				res_q <= (st_q == S_OP1) ? S_OP2 : S_PAY;
			end else if (st_q == S_EXEC) begin
				cont_q <= 1'b0;
			end
			if (acc) begin
				case (st_q)
				S_FLG: if (!cont_q) flags_q <= rx_data;
				S_SEQ: begin
					if (!cont_q) seq_q <= rx_data; // RULE5
					seq_exp_q <= rx_data + 8'h01;
				end
				S_LEN0: len_lo_q <= rx_data; // RULE8
				S_LEN1: begin
					rem_q <= {rx_data, len_lo_q}; // RULE6
					plen_q <= {rx_data, len_lo_q} - OPC_BYTES;
				end
				S_OP1: begin
					op1_q <= rx_data; // RULE7
					rem_q <= rem_q - 16'h0001;
				end
				S_OP2: begin
					op2_q <= rx_data; // RULE7
					rem_q <= rem_q - 16'h0001;
					pidx_q <= 4'h0;
				end
				S_PAY: begin
					if (pidx_q < PAY_KEEP) begin
						pay_q[pidx_q[2:0]*8 +: 8] <= rx_data; // RULE8
						pidx_q <= pidx_q + 4'h1;
					end
					rem_q <= rem_q - 16'h0001;
				end
				default: rem_q <= rem_q;
				endcase
			end
		end
	end

	assign exec = (st_q == S_EXEC);
	assign info = cmd_info(op1_q, op2_q);
	assign known = info[5];
	assign rd = info[4];
	assign tm = info[3];
	assign badp = (tm & ~rd) ? (plen_q != TIME_PLEN) : (plen_q != 16'h0000);
	// Direction must agree with the command; a write with bit 7 set fails.
	assign nack = err_q | ~known | badp |
		(flags_q[FLG_READ] != rd); // RULE3 RULE16 RULE11

	// Reply set-up, sent only on request.
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			start_q <= 1'b0;
			rep_st_q <= 8'h00;
			rep_len_q <= 4'h0;
			rep_data_q <= '0;
		end else begin
			start_q <= exec & flags_q[FLG_REPLY]; // RULE2 RULE12
			if (exec) begin
				rep_st_q <= {flags_q[FLG_READ], flags_q[FLG_REPLY], nack,
					5'h00}; // RULE11
				rep_len_q <= (rd & ~nack) ? (tm ? DLEN_TIME : DLEN_WORD) :
					4'h0; // RULE10
				rep_data_q <= (rd & ~nack) ? (tm ?
					{data_q[IX_TIME_HI], data_q[IX_TIME_LO]} :
					{32'h0000_0000, data_q[info[2:0]]}) : '0; // RULE10
			end
		end
	end

	hcpi_tx u_tx (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.start(start_q),
		.status(rep_st_q),
		.seq(seq_q),
		.dlen(rep_len_q),
		.data(rep_data_q),
		.tx_ready(tx_ready),
		.tx_valid(tx_valid),
		.tx_data(tx_data),
		.tx_last(tx_last),
		.done(tx_done)
	);

	assign apb_acc = psel & penable & pready_q;
	assign apb_hit = (paddr[1:0] == 2'b00) && (paddr <= A_LAST);

	// APB answers with one wait state so read data comes from a flop.
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else begin
			pready_q <= psel & penable & ~pready_q;
			pslverr_q <= psel & penable & ~pready_q & ~apb_hit;
			prdata_q <= 32'h0000_0000;
			if (psel && penable && !pready_q && !pwrite && apb_hit) begin
				case (paddr)
				A_CTRL: prdata_q <= {31'h0000_0000, en_q};
				A_STAT: prdata_q <= {27'h000_0000, stat_q};
				A_MASK: prdata_q <= {27'h000_0000, mask_q};
				A_INFO: prdata_q <= {8'h00, op1_q, op2_q, 6'h00,
					(st_q != S_RID), hib_q};
				default: prdata_q <= data_q[paddr[4:2] - 3'h4];
				endcase
			end
		end
	end

	// Software-written values and the time set by command.
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			for (int i = 0; i < 8; i++) begin
				data_q[i] <= 32'h0000_0000;
			end
			en_q <= CTRL_EN_RESET;
			mask_q <= MASK_RESET;
		end else begin
			if (apb_acc && pwrite && paddr == A_CTRL) begin
				en_q <= pwdata[CTRL_EN];
			end
			if (apb_acc && pwrite && paddr == A_MASK) begin
				mask_q <= pwdata[EV_W-1:0];
			end
			if (apb_acc && pwrite && apb_hit && paddr >= A_DATA0) begin
				data_q[paddr[4:2] - 3'h4] <= pwdata;
			end
			// The host's time command wins over a software write.
			if (exec && !nack && tm && !rd) begin
				data_q[IX_TIME_LO] <= pay_q[31:0]; // RULE14 RULE8
				data_q[IX_TIME_HI] <= pay_q[63:32];
			end
		end
	end

	// Hibernation request stays up until software clears it; set wins.
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			hib_q <= 1'b0;
		end else if (exec && !nack && known && !rd && !tm) begin
			hib_q <= 1'b1; // RULE14
		end else if (apb_acc && pwrite && paddr == A_CTRL &&
			pwdata[CTRL_HIB_CLR]) begin
			hib_q <= 1'b0;
		end
	end

	assign ev = {exec & err_q, exec & ~nack & known & ~rd & ~tm,
		exec & ~nack & tm & ~rd, exec & nack, exec};
	// Status clears at the edge that captures the read data, so an event in
	// the wait state is kept; a new event in that cycle survives.
	assign stat_d = (stat_q & ~((psel && penable && !pready_q && !pwrite &&
		paddr == A_STAT) ? {EV_W{1'b1}} : {EV_W{1'b0}})) | ev;

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			stat_q <= '0;
			irq_q <= 1'b0;
		end else begin
			stat_q <= stat_d;
			irq_q <= |(stat_d & mask_q);
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign rx_ready = rx_ready_q;
	assign hibernate = hib_q;
	assign irq = irq_q;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);

	sequence s_hdr_out;
		(tx_valid && tx_ready) ##1 (tx_valid && tx_ready);
	endsequence

	chk_reply_request: assert property ( // RULE2
		start_q |-> $past(flags_q[FLG_REPLY]) && $past(exec))
		else $error("reply started without a reply request");
	chk_write_silent: assert property ( // RULE12
		exec && !flags_q[FLG_REPLY] |=> !start_q ##1 !tx_valid)
		else $error("reply sent without a reply request");
	chk_nack_bit: assert property ( // RULE11
		exec && flags_q[FLG_REPLY] && nack |=> ##1 tx_valid && tx_data[ST_NACK])
		else $error("negative acknowledge missing from reply");
	chk_seq_echo: assert property ( // RULE10
		start_q ##1 s_hdr_out |=> tx_data == {4'h0, rep_len_q} &&
		$past(tx_data) == seq_q)
		else $error("reply sequence or length byte wrong");
	chk_pkt_limit: assert property ( // RULE9
		acc && !rx_sop && pcnt_q == PKT_MAX |=> err_q)
		else $error("oversize report not flagged");
	chk_seq_order: assert property ( // RULE4
		acc && st_q == S_SEQ && cont_q && rx_data != seq_exp_q |=> err_q)
		else $error("out of order sequence not flagged");
	chk_read_dir: assert property ( // RULE3
		exec && known && !rd && flags_q[FLG_READ] |=> rep_st_q[ST_NACK])
		else $error("write command marked read not refused");
	chk_time_set: assert property ( // RULE14
		exec && !nack && tm && !rd |=> data_q[IX_TIME_LO] == $past(pay_q[31:0]))
		else $error("time register not loaded from payload");
	chk_hib_hold: assert property ( // RULE14
		exec && !nack && known && !rd && !tm |=> hibernate [*3])
		else $error("hibernation request not held");
	chk_len_count: assert property ( // RULE6
		acc && st_q == S_LEN1 && !lenbad && !rx_eop |=> st_q == S_OP1 &&
		rem_q == {$past(rx_data), len_lo_q})
		else $error("length field not taken as opcode plus payload count");
	chk_rx_stall: assert property (
		st_q == S_SEND |-> !rx_ready)
		else $error("receive ready while replying");
endmodule : hcpi_top

// >>> verilog/hcpi_tx.sv
// Reply serializer: sends status, sequence, length and data bytes.
module hcpi_tx
	import hcpi_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic start,
	input wire logic [7:0] status,
	input wire logic [7:0] seq,
	input wire logic [3:0] dlen,
	input wire logic [63:0] data,
	input wire logic tx_ready,
	output logic tx_valid,
	output logic [7:0] tx_data,
	output logic tx_last,
	output logic done
);
	logic [95:0] sh_q;
	logic [3:0] cnt_q;
	logic tx_valid_q;
	logic tx_last_q;
	logic done_q;
	logic [3:0] total;

	assign total = dlen + HDR_BYTES;
	assign tx_valid = tx_valid_q;
	assign tx_data = sh_q[7:0];
	assign tx_last = tx_last_q;
	assign done = done_q;

	// Length and data go out low byte first.
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			sh_q <= '0;
			cnt_q <= 4'h0;
			tx_valid_q <= 1'b0;
			tx_last_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (start) begin
				sh_q <= {data, 12'h000, dlen, seq, status}; // RULE8 RULE10
				cnt_q <= total;
				tx_valid_q <= 1'b1;
				tx_last_q <= 1'b0;
			end else if (tx_valid_q && tx_ready) begin
				sh_q <= {8'h00, sh_q[95:8]};
				cnt_q <= cnt_q - 4'h1;
				tx_last_q <= (cnt_q == 4'h2);
				if (cnt_q == 4'h1) begin
					tx_valid_q <= 1'b0;
					done_q <= 1'b1;
				end
			end
		end
	end
endmodule : hcpi_tx
